// file: core/extended_positioning_function_top.sv
// Cyclic positioning profile for one servo axis with APB parameter block
// Assumes synchronous inputs on pclk; drive channel sampled once per cycle tick
`timescale 1ns/100ps
`default_nettype none
module extended_positioning_function_top #(
  parameter int HALF_MS_CYCLES = extended_positioning_function_pkg::HALF_MS_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic start_continue_input,
  input wire logic stop_input,
  input wire logic ref_signal,
  input wire logic [31:0] master_speed,
  input wire logic [31:0] speed_feedback,
  output logic [31:0] drive_vel,
  output logic [31:0] drive_step,
  output logic drive_valid,
  output logic speed_match_output,
  output logic active
);
  import extended_positioning_function_pkg::*;
  extended_positioning_function_ovr_if ovr_c ();
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic [4:0] mode_sh_r, mode_r;
  logic [7:0] cyc_sh_r, cyc_r;
  logic [31:0] trav_sh_r, trav_r;
  logic [31:0] vel_sh_r, vel_r;
  logic [31:0] acc_sh_r, acc_r;
  logic [31:0] dec_sh_r, dec_r;
  logic [31:0] enc_sh_r, menc_sh_r;
  logic [15:0] ovr_sh_r, ovr_r;
  logic [15:0] flag_r [64];
  logic armed_r, err_r, pend_r, start_d_r;
  logic [31:0] tick_cnt_r;
  logic tick;
  extended_positioning_function_state_t st_r;
  logic [31:0] v_r, rem_r, adist_r;
  logic dir_r;
  logic [31:0] drive_vel_r, drive_step_r;
  logic drive_valid_r, match_r;
  logic wr, rd, cmd_wr, ok, start_rise;
  logic [31:0] vt, acc_e, step, vnext;
  assign pready = pready_r;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;
  assign drive_vel = drive_vel_r;
  assign drive_step = drive_step_r;
  assign drive_valid = drive_valid_r;
  assign speed_match_output = match_r;
  assign active = (st_r != S_IDLE);
  assign wr = psel && penable && pready_r && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign cmd_wr = wr && (paddr == OFF_CMD);
  assign start_rise = start_continue_input && !start_d_r;
  // Parameter plausibility, checked against the shadow block before use
  always_comb begin
    ok = 1'b1;
    if (cyc_sh_r == 8'h00) ok = 1'b0;
    if (!mode_sh_r[MB_SUBST] && cyc_sh_r > CYC_REL_MAX) ok = 1'b0;
    if (mode_sh_r[MB_SUBST] && (cyc_sh_r < CYC_SUB_MIN || cyc_sh_r > CYC_SUB_MAX)) begin
      ok = 1'b0;
    end
    if (vel_sh_r == 32'h0000_0000) ok = 1'b0;
    if (acc_sh_r == 32'h0000_0000 || acc_sh_r[31] || acc_sh_r > ACC_MAX) ok = 1'b0;
    if (dec_sh_r < acc_sh_r || dec_sh_r > ACC_MAX) ok = 1'b0;
    if (enc_sh_r[31] || enc_sh_r == 32'h0000_0000) ok = 1'b0;
    if (mode_sh_r[MB_EXT] && (menc_sh_r[31] || menc_sh_r == 32'h0000_0000)) begin
      ok = 1'b0;
    end
  end
  // APB slave: pready raised in the access phase, no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= psel && !penable;
      pslverr_r <= psel && !penable && (paddr[1:0] != 2'b00 ||
                   (paddr > OFF_REMAIN && paddr < OFF_FLAG) || paddr > 12'h1FC);
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (rd) begin
      case (paddr)
        OFF_MODE: prdata_r <= {27'h000_0000, mode_sh_r};
        OFF_CYCLE: prdata_r <= {24'h00_0000, cyc_sh_r};
        OFF_TRAVEL: prdata_r <= trav_sh_r;
        OFF_VEL: prdata_r <= vel_sh_r;
        OFF_ACC: prdata_r <= acc_sh_r;
        OFF_DEC: prdata_r <= dec_sh_r;
        OFF_ENC: prdata_r <= enc_sh_r;
        OFF_MENC: prdata_r <= menc_sh_r;
        OFF_OVR: prdata_r <= {16'h0000, ovr_sh_r};
        OFF_STATUS: prdata_r <= {24'h00_0000, match_r, dir_r, err_r, armed_r,
                                 1'b0, 3'(st_r)};
        OFF_CURVEL: prdata_r <= v_r;
        OFF_REMAIN: prdata_r <= rem_r;
        default: begin
          if (paddr >= OFF_FLAG && paddr <= 12'h1FC) begin
            prdata_r <= {16'h0000, flag_r[paddr[7:2]]};
          end else begin
            prdata_r <= 32'h0000_0000;
          end
        end
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_sh_r <= MODE_RST;
      cyc_sh_r <= CYCLE_RST;
      trav_sh_r <= 32'h0000_0000;
      vel_sh_r <= 32'h0000_0001;
      acc_sh_r <= 32'h0000_0001;
      dec_sh_r <= 32'h0000_0001;
      enc_sh_r <= 32'h0000_0001;
      menc_sh_r <= 32'h0000_0001;
      ovr_sh_r <= 16'h0000;
    end else if (wr) begin
      case (paddr)
        OFF_MODE: mode_sh_r <= pwdata[4:0];
        OFF_CYCLE: cyc_sh_r <= pwdata[7:0];
        OFF_TRAVEL: trav_sh_r <= pwdata;
        OFF_VEL: vel_sh_r <= pwdata;
        OFF_ACC: acc_sh_r <= pwdata;
        OFF_DEC: dec_sh_r <= pwdata;
        OFF_ENC: enc_sh_r <= pwdata;
        OFF_MENC: menc_sh_r <= pwdata;
        OFF_OVR: ovr_sh_r <= pwdata[15:0];
        default: ;
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 64; i++) flag_r[i] <= 16'h0000;
    end else if (wr && paddr >= OFF_FLAG && paddr <= 12'h1FC) begin
      flag_r[paddr[7:2]] <= pwdata[15:0];
    end
  end
  // Commands: a plausible start, or value-new while armed, copies the shadow block except the encoder words into the working set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_r <= 1'b0;
      err_r <= 1'b0;
      mode_r <= MODE_RST;
      cyc_r <= CYCLE_RST;
      trav_r <= 32'h0000_0000;
      vel_r <= 32'h0000_0001;
      acc_r <= 32'h0000_0001;
      dec_r <= 32'h0000_0001;
      ovr_r <= 16'h0000;
    end else if (cmd_wr) begin
      case (pwdata[7:0])
        CMD_RESET: begin
          armed_r <= 1'b0;
          err_r <= 1'b0;
        end
        CMD_START, CMD_NEW: begin
          err_r <= !ok;
          if (ok && (pwdata[7:0] == CMD_START || armed_r)) begin
            armed_r <= 1'b1;
            mode_r <= mode_sh_r;
            cyc_r <= cyc_sh_r;
            trav_r <= trav_sh_r;
            vel_r <= vel_sh_r;
            acc_r <= acc_sh_r;
            dec_r <= dec_sh_r;
            ovr_r <= ovr_sh_r;
          end
        end
        default: err_r <= 1'b1;
      endcase
    end
  end
  // Cycle period counter; one tick every cyc_r half-milliseconds
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_r <= 32'h0000_0000;
    end else if (tick || !armed_r) begin
      tick_cnt_r <= 32'h0000_0000;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
    end
  end
  assign tick = armed_r && (tick_cnt_r == 32'(cyc_r * HALF_MS_CYCLES - 1));
  // Start edges are held until the next tick; a new edge beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_d_r <= 1'b0;
      pend_r <= 1'b0;
    end else begin
      start_d_r <= start_continue_input;
      if (start_rise && armed_r) begin
        pend_r <= 1'b1;
      end else if (tick || !armed_r) begin
        pend_r <= 1'b0;
      end
    end
  end
  assign ovr_c.vel_in = mode_r[MB_EXT] ? extended_positioning_function_abs(master_speed) : extended_positioning_function_abs(vel_r);
  assign ovr_c.acc_in = acc_r;
  assign ovr_c.vel_en = (ovr_r[7:0] != 8'h00);
  assign ovr_c.acc_en = (ovr_r[15:8] != 8'h00);
  assign ovr_c.vel_word = flag_r[extended_positioning_function_flag_idx(ovr_r[7:0])];
  assign ovr_c.acc_word = flag_r[extended_positioning_function_flag_idx(ovr_r[15:8])];
  assign ovr_c.start_rise = start_rise;
  extended_positioning_function_ovr u_ovr (
    .pclk(pclk),
    .presetn(presetn),
    .o(ovr_c.core)
  );
  assign vt = ovr_c.vel_out;
  assign acc_e = ovr_c.acc_out;
  always_comb begin
    if (v_r < vt) begin
      vnext = (vt - v_r > acc_e) ? v_r + acc_e : vt;
    end else if (v_r > vt) begin
      vnext = (v_r - vt > acc_e) ? v_r - acc_e : vt;
    end else begin
      vnext = v_r;
    end
    step = (st_r == S_SEEK || st_r == S_STOP) ? v_r : ((v_r > rem_r) ? rem_r : v_r);
  end
  // Profile state machine, advanced once per tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= S_IDLE;
      v_r <= 32'h0000_0000;
      rem_r <= 32'h0000_0000;
      adist_r <= 32'h0000_0000;
      dir_r <= 1'b0;
    end else if (!armed_r) begin
      st_r <= S_IDLE;
      v_r <= 32'h0000_0000;
      rem_r <= 32'h0000_0000;
    end else if (tick) begin
      case (st_r)
        S_IDLE: begin
          if (pend_r && !stop_input) begin
            adist_r <= 32'h0000_0000;
            if (mode_r[MB_SUBST]) begin
              st_r <= S_SEEK;
              dir_r <= vel_r[31];
            end else begin
              st_r <= S_RUN;
              rem_r <= extended_positioning_function_abs(trav_r);
              dir_r <= trav_r[31];
            end
          end
        end
        S_SEEK: begin
          v_r <= vnext;
          if (stop_input) begin
            st_r <= S_STOP;
          end else if (ref_signal) begin
            st_r <= S_RUN;
            rem_r <= extended_positioning_function_abs(trav_r);
          end
        end
        S_RUN, S_RAMP: begin
          if (stop_input) begin
            st_r <= S_STOP;
          end else if (pend_r && mode_r[MB_RETRIG] && !mode_r[MB_MOD] &&
                       !mode_r[MB_SUBST] && (trav_r[31] == dir_r || mode_r[MB_REV])) begin
            st_r <= S_RUN;
            dir_r <= trav_r[31];
            rem_r <= extended_positioning_function_abs(trav_r);
            adist_r <= 32'h0000_0000;
          end else if (rem_r <= step) begin
            rem_r <= 32'h0000_0000;
            v_r <= 32'h0000_0000;
            st_r <= S_IDLE;
          end else if (st_r == S_RUN && rem_r - step <= adist_r) begin
            if (mode_r[MB_MOD] && start_continue_input) begin
              rem_r <= rem_r - step + extended_positioning_function_abs(trav_r);
            end else begin
              rem_r <= rem_r - step;
              st_r <= S_RAMP;
            end
          end else begin
            rem_r <= rem_r - step;
            if (st_r == S_RUN) begin
              v_r <= vnext;
              if (vnext > v_r) adist_r <= adist_r + vnext;
            end else begin
              // Creep at one acceleration step so the last increments are reached
              v_r <= (v_r > acc_e + acc_e) ? v_r - acc_e : acc_e;
            end
          end
        end
        S_STOP: begin
          v_r <= (v_r > dec_r) ? v_r - dec_r : 32'h0000_0000;
          if (v_r <= dec_r) st_r <= S_IDLE;
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end
  // Drive channel outputs, refreshed each tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_vel_r <= 32'h0000_0000;
      drive_step_r <= 32'h0000_0000;
      drive_valid_r <= 1'b0;
    end else if (tick) begin
      drive_valid_r <= (st_r != S_IDLE) && !ovr_c.vel_blank;
      drive_vel_r <= dir_r ? 32'(-v_r) : v_r;
      drive_step_r <= (st_r == S_IDLE) ? 32'h0000_0000 : (dir_r ? 32'(-step) : step);
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_r <= 1'b0;
    end else begin
      match_r <= mode_r[MB_MOD] && armed_r && (speed_feedback == drive_vel_r);
    end
  end
  a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready) else $error("pready missing in access phase");
  a_idle_no_valid: assert property (@(posedge pclk) disable iff (!presetn)
    tick && st_r == S_IDLE |=> !drive_valid) else $error("valid while idle");
  a_match_mode: assert property (@(posedge pclk) disable iff (!presetn)
    speed_match_output |-> $past(mode_r[MB_MOD])) else $error("match outside modulo");
  a_match_equal: assert property (@(posedge pclk) disable iff (!presetn)
    armed_r && mode_r[MB_MOD] && $stable(mode_r) && $stable(armed_r) &&
    speed_feedback == drive_vel_r |=> speed_match_output) else $error("match low");
  a_reset_cmd: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_wr && pwdata[7:0] == CMD_RESET |=> !armed_r ##1 !active)
    else $error("reset command ignored");
  a_tick_period: assert property (@(posedge pclk) disable iff (!presetn)
    tick |=> !tick) else $error("tick too close");
  a_no_retrig: assert property (@(posedge pclk) disable iff (!presetn)
    tick && st_r == S_RUN && !mode_r[MB_RETRIG] && !mode_r[MB_MOD] && !stop_input &&
    rem_r > step
    |=> rem_r == $past(rem_r) - $past(step) || st_r == S_RAMP)
    else $error("retrigger without enable");
  a_bad_param: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_wr && pwdata[7:0] == CMD_START && !ok |=> err_r) else $error("bad block accepted");
  a_stop_ramp: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == S_STOP && tick |=> st_r == S_STOP || st_r == S_IDLE || !armed_r)
    else $error("stop ramp left");
  c_run: cover property (@(posedge pclk) st_r == S_RUN ##1 st_r == S_RAMP);
  c_seek: cover property (@(posedge pclk) st_r == S_SEEK ##1 st_r == S_RUN);
  c_match: cover property (@(posedge pclk) speed_match_output);
  c_stop: cover property (@(posedge pclk) st_r == S_STOP);
endmodule
`default_nettype wire

// file: core/extended_positioning_function_pkg.sv
// Package for the positioning profile block: register map, fields, timing
// Assumes a 20 MHz pclk and 32-bit APB data
package extended_positioning_function_pkg;
  localparam logic [11:0] OFF_CMD = 12'h000;
  localparam logic [11:0] OFF_MODE = 12'h004;
  localparam logic [11:0] OFF_CYCLE = 12'h008;
  localparam logic [11:0] OFF_TRAVEL = 12'h00C;
  localparam logic [11:0] OFF_VEL = 12'h010;
  localparam logic [11:0] OFF_ACC = 12'h014;
  localparam logic [11:0] OFF_DEC = 12'h018;
  localparam logic [11:0] OFF_ENC = 12'h01C;
  localparam logic [11:0] OFF_MENC = 12'h020;
  localparam logic [11:0] OFF_OVR = 12'h024;
  localparam logic [11:0] OFF_STATUS = 12'h028;
  localparam logic [11:0] OFF_CURVEL = 12'h02C;
  localparam logic [11:0] OFF_REMAIN = 12'h030;
  localparam logic [11:0] OFF_FLAG = 12'h100;
  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam logic [7:0] CMD_START = 8'h01;
  localparam logic [7:0] CMD_NEW = 8'h05;
  localparam int MB_EXT = 0;
  localparam int MB_SUBST = 1;
  localparam int MB_REV = 2;
  localparam int MB_RETRIG = 3;
  localparam int MB_MOD = 4;
  localparam logic [7:0] CYC_REL_MAX = 8'h83;
  localparam logic [7:0] CYC_SUB_MIN = 8'h02;
  localparam logic [7:0] CYC_SUB_MAX = 8'h12;
  localparam logic [31:0] ACC_MAX = 32'h05F5_E100;
  localparam logic [15:0] OVR_UNITY = 16'h0400;
  localparam logic [15:0] ACC_OVR_MIN = 16'h0066;
  localparam int OVR_SHIFT = 10;
  localparam int HALF_MS_NS = 500000;
  localparam int CLK_NS = 50;
  localparam int HALF_MS_CYC = HALF_MS_NS / CLK_NS;
  localparam logic [4:0] MODE_RST = 5'h00;
  localparam logic [7:0] CYCLE_RST = 8'h01;
  typedef enum logic [2:0] {S_IDLE, S_SEEK, S_RUN, S_RAMP, S_STOP} extended_positioning_function_state_t;
  // Odd flag addresses fold onto the next lower even word
  function automatic logic [5:0] extended_positioning_function_flag_idx(input logic [7:0] a);
    return a[6:1];
  endfunction
  function automatic logic [31:0] extended_positioning_function_abs(input logic [31:0] v);
    return v[31] ? 32'(-v) : v;
  endfunction
endpackage

// file: core/extended_positioning_function_ovr_if.sv
// Override path between profile core and override unit
// Assumes both ends share pclk
`timescale 1ns/100ps
`default_nettype none
interface extended_positioning_function_ovr_if;
  logic [31:0] vel_in;
  logic [31:0] acc_in;
  logic [15:0] vel_word;
  logic [15:0] acc_word;
  logic vel_en;
  logic acc_en;
  logic start_rise;
  logic [31:0] vel_out;
  logic [31:0] acc_out;
  logic vel_blank;
  modport core (output vel_in, acc_in, vel_word, acc_word, vel_en, acc_en, start_rise,
                input vel_out, acc_out, vel_blank);
  modport ovr (input vel_in, acc_in, vel_word, acc_word, vel_en, acc_en, start_rise,
               output vel_out, acc_out, vel_blank);
endinterface
`default_nettype wire

// file: core/extended_positioning_function_ovr.sv
// Velocity and acceleration override unit
// Assumes flag words are presented by the core each clock
`timescale 1ns/100ps
`default_nettype none
module extended_positioning_function_ovr (
  input wire logic pclk,
  input wire logic presetn,
  extended_positioning_function_ovr_if.ovr o
);
  import extended_positioning_function_pkg::*;
  logic [15:0] acc_ovr_r;
  logic [15:0] acc_clamp;
  logic [47:0] vprod;
  logic [47:0] aprod;
  always_comb begin
    if (o.acc_word <= ACC_OVR_MIN) begin
      acc_clamp = ACC_OVR_MIN;
    end else if (o.acc_word > OVR_UNITY) begin
      acc_clamp = OVR_UNITY;
    end else begin
      acc_clamp = o.acc_word;
    end
  end
  // Sampled only on a start edge so a moving axis keeps a steady ramp
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_ovr_r <= OVR_UNITY;
    end else if (o.start_rise) begin
      acc_ovr_r <= o.acc_en ? acc_clamp : OVR_UNITY;
    end
  end
  assign vprod = o.vel_in * {1'b0, o.vel_word[14:0]};
  assign aprod = o.acc_in * acc_ovr_r;
  always_comb begin
    o.vel_out = o.vel_en ? vprod[OVR_SHIFT +: 32] : o.vel_in;
    o.vel_blank = o.vel_en && (o.vel_word[14:0] == 15'h0000);
    o.acc_out = (aprod[OVR_SHIFT +: 32] == 32'h0000_0000) ? 32'h0000_0001
                : aprod[OVR_SHIFT +: 32];
  end
endmodule
`default_nettype wire

// file: bench/extended_positioning_function_drive_model.sv
// Servo drive stand-in: speed feedback and reference signal
// Assumes drive_vel/drive_valid from the profile block on pclk
`timescale 1ns/100ps
`default_nettype none
module extended_positioning_function_drive_model #(
  parameter int REF_DELAY = 40
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [31:0] drive_vel,
  input wire logic drive_valid,
  input wire logic slow,
  output logic [31:0] speed_feedback,
  output logic ref_signal
);
  logic [31:0] tgt;
  int cnt;
  assign tgt = drive_valid ? drive_vel : 32'h0000_0000;
  // Slow mode lags one increment per clock so speed match must drop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      speed_feedback <= 32'h0000_0000;
    end else if (!slow || speed_feedback == tgt) begin
      speed_feedback <= tgt;
    end else begin
      speed_feedback <= ($signed(speed_feedback) < $signed(tgt)) ? speed_feedback + 1
                        : speed_feedback - 1;
    end
  end
  // Homing already commanded; reference arrives after a while in motion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      ref_signal <= 1'b0;
    end else begin
      cnt <= drive_valid ? cnt + 1 : 0;
      ref_signal <= (cnt >= REF_DELAY);
    end
  end
endmodule
`default_nettype wire

// file: bench/test_extended_positioning_profile.sv
// Self-checking bench for the positioning profile block
// Assumes APB slave with no wait state and a prompt or slow drive model
`timescale 1ns/100ps
`default_nettype none
module test_extended_positioning_profile;
  import extended_positioning_function_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, start_in, slow;
  logic ref_sig, drive_valid, speed_match_output, active, stop_in;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, drive_vel, drive_step, fb, q;
  logic e;
  int err_count, tests_run;
  extended_positioning_function_top #(.HALF_MS_CYCLES(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .start_continue_input(start_in),
    .stop_input(stop_in), .ref_signal(ref_sig), .master_speed(32'h0000_0000),
    .speed_feedback(fb), .drive_vel(drive_vel), .drive_step(drive_step),
    .drive_valid(drive_valid), .speed_match_output(speed_match_output), .active(active));
  extended_positioning_function_drive_model drv (.pclk(pclk), .presetn(presetn), .drive_vel(drive_vel),
    .drive_valid(drive_valid), .slow(slow), .speed_feedback(fb), .ref_signal(ref_sig));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n >= 100) err_count++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic setup(input logic [31:0] m, cy, tr, v, ac, de, en, ov);
    apb(1, OFF_MODE, m);
    apb(1, OFF_CYCLE, cy);
    apb(1, OFF_TRAVEL, tr);
    apb(1, OFF_VEL, v);
    apb(1, OFF_ACC, ac);
    apb(1, OFF_DEC, de);
    apb(1, OFF_ENC, en);
    apb(1, OFF_MENC, en);
    apb(1, OFF_OVR, ov);
  endtask
  // Starts, then samples motion; hold keeps the start input high for the 400 sampled clocks
  task automatic run_move(input logic hold, output logic [31:0] vmax, output int nm,
                          output logic neg);
    logic [31:0] m;
    vmax = 0;
    nm = 0;
    neg = 0;
    apb(1, OFF_CMD, {24'h00_0000, CMD_START});
    start_in <= 1'b1;
    repeat (400) begin
      @(posedge pclk);
      start_in <= hold;
      m = drive_vel[31] ? -drive_vel : drive_vel;
      if (drive_valid === 1'b1 && m > vmax) vmax = m;
      if (drive_valid === 1'b1 && m != 0) neg |= drive_vel[31];
      if (speed_match_output === 1'b1) nm++;
    end
    chk("active_held", active, hold);
    start_in <= 1'b0;
    repeat (4000) if (active !== 1'b0) @(posedge pclk);
    chk("active_end", active, 1'b0);
  endtask
  task automatic t_regs;
    apb(0, OFF_MODE, 0);
    chk("mode_rst", q, {27'h0, MODE_RST});
    apb(0, OFF_CYCLE, 0);
    chk("cycle_rst", q, {24'h0, CYCLE_RST});
    apb(0, 12'h0FC, 0);
    chk("unmapped", {e, q[30:0]}, 32'h8000_0000);
    apb(1, OFF_CMD, 32'h0000_0003);
    apb(0, OFF_STATUS, 0);
    chk("bad_code", q[5], 1'b1);
    apb(1, OFF_MODE, 32'h0000_001F);
    apb(0, OFF_MODE, 0);
    chk("mode_max", q, 32'h0000_001F);
  endtask
  task automatic t_bad;
    logic [31:0] tb[6][4] = '{'{0, 0, 5, 9}, '{0, 132, 5, 9}, '{2, 1, 5, 9},
      '{2, 4, 0, 9}, '{0, 1, 5, 8}, '{0, 1, 5, 0}};
    for (int i = 0; i < 6; i++) begin
      setup(tb[i][0], tb[i][1], 40, tb[i][2], 9, tb[i][3], tb[i][3], 0);
      apb(1, OFF_CMD, {24'h00_0000, CMD_START});
      apb(0, OFF_STATUS, 0);
      chk("param_err", {q[5], q[2:0]}, 4'h8);
      apb(1, OFF_CMD, {24'h00_0000, CMD_RESET});
    end
  endtask
  task automatic t_moves;
    logic [31:0] vm;
    int nm;
    logic ng;
    setup(0, 1, -40, 5, 1000, 1000, 4096, 0);
    run_move(0, vm, nm, ng);
    chk("neg_dir", ng, 1'b1);
    chk("vel_max", vm, 5);
    chk("no_match", nm != 0, 1'b0);
    apb(0, OFF_REMAIN, 0);
    chk("remain", q, 0);
    setup(0, 1, 40, -8, 1000, 1000, 4096, 3);
    apb(1, OFF_FLAG + 12'h004, 512);
    run_move(0, vm, nm, ng);
    chk("pos_dir", ng, 1'b0);
    chk("ovr_half", vm, 4);
    // Zero override holds the axis in place, so only a stop ramp ends it
    apb(1, OFF_FLAG + 12'h004, 0);
    apb(1, OFF_CMD, {24'h00_0000, CMD_START});
    start_in <= 1'b1;
    vm = 0;
    repeat (100) begin
      @(posedge pclk);
      start_in <= 1'b0;
      if (drive_valid !== 1'b0) vm = 1;
    end
    chk("ovr_zero", vm, 0);
    chk("ovr_hold", active, 1'b1);
    stop_in <= 1'b1;
    repeat (20) @(posedge pclk);
    chk("stop_end", active, 1'b0);
    stop_in <= 1'b0;
    setup(32'h0000_0010, 1, 20, 5, 1000, 1000, 4096, 0);
    run_move(1, vm, nm, ng);
    chk("match_seen", nm != 0, 1'b1);
  endtask
  task automatic report_and_stop;
    $display("Checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #(50 * 100000);
    err_count++;
    report_and_stop();
  end
  initial begin
    err_count = 0;
    tests_run = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, start_in, slow, stop_in} = 6'b000000;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_bad();
    t_moves();
    report_and_stop();
  end
endmodule
`default_nettype wire
